// File: hdl/cer_params.svh
// register offsets, field positions, reset values and timing counts of the calibration/enhancement bank
`ifndef CER_PARAMS_SVH
`define CER_PARAMS_SVH

`define CER_ADDR_MON_OFS   8'h67
`define CER_ADDR_TRIM      8'h68
`define CER_ADDR_DAC_OFFSET_VALUE     8'h69
`define CER_ADDR_COMMON_MODE_VALUE     8'h6a
`define CER_ADDR_PEAK      8'h6b
`define CER_ADDR_ENH       8'h6c

`define CER_RST_MON_OFS    8'h00
`define CER_RST_TRIM       4'h0
`define CER_RST_DAC_OFFSET_VALUE      8'h00
`define CER_RST_COMMON_MODE_VALUE      6'h00
`define CER_RST_PEAK       4'h8
`define CER_RST_ENH        8'h00

`define CER_MON_A_HI       7
`define CER_MON_A_LO       4
`define CER_MON_B_HI       3
`define CER_MON_B_LO       0
`define CER_TRIM_DAC_POSITIVE_TRIM      3
`define CER_TRIM_DAC_NEGATIVE_TRIM      2
`define CER_TRIM_ADC_POSITIVE_TRIM      1
`define CER_TRIM_ADC_NEGATIVE_TRIM      0
`define CER_COMMON_MODE_VALUE_HI       5
`define CER_PEAK_HI        3

`define CER_ENH_PROGRAMMED_CURRENT_LIMIT       7
`define CER_ENH_FSK        6
`define CER_ENH_CONVERTER_SPEEDUP       5
`define CER_ENH_EXTERNAL_IMPEDANCE_REF      4
`define CER_ENH_BATTERY_SWITCH_DEBOUNCE       3
`define CER_ENH_VOLTAGE_LOOP_CLOSURE       2
`define CER_ENH_CONVERTER_SQUELCH      1
`define CER_ENH_HYST       0

`define CER_PROGRAMMED_CURRENT_LIMIT_BOOST_MA  6'd41

`define CER_CLK_HZ         100000000
`define CER_CLK_MHZ        100
`define CER_TONE_SLOW_HZ   8000
`define CER_TONE_FAST_HZ   24000
`define CER_TONE_SLOW_CYC  (`CER_CLK_HZ / `CER_TONE_SLOW_HZ)
`define CER_TONE_FAST_CYC  (`CER_CLK_HZ / `CER_TONE_FAST_HZ)
`define CER_BATTERY_SWITCH_DEBOUNCE_MS        60
`define CER_BATTERY_SWITCH_DEBOUNCE_CYC       (`CER_BATTERY_SWITCH_DEBOUNCE_MS * `CER_CLK_MHZ * 1000)
`define CER_BOOST_US       1000
`define CER_BOOST_CYC      (`CER_BOOST_US * `CER_CLK_MHZ)

`endif

// File: hdl/cer_pkg.sv
// types of the calibration/enhancement bank
package cer_pkg;

  typedef enum logic [1:0] {
    CER_BATT_HIGH = 2'b00,
    CER_BATT_WAIT = 2'b01,
    CER_BATT_LOW  = 2'b10
  } cer_batt_state_t;

  typedef logic [7:0] cer_byte_t;

endpackage : cer_pkg

// File: hdl/cer_tick_if.sv
// tick strobe carried from a rate generator to its user
`timescale 1ns/100ps
interface cer_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface : cer_tick_if

// File: hdl/cer_tick_gen.sv
// free running divider giving a one-cycle tick every DIV clocks
`timescale 1ns/100ps
module cer_tick_gen #(
  parameter int unsigned DIV = 12500
) (
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst_n,
  cer_tick_if.src    o_tick_port
);

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;
  logic          tick_ff;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end else if (cnt_ff == LAST) begin
      cnt_ff  <= '0;
      tick_ff <= 1'b1;
    end else begin
      cnt_ff  <= cnt_ff + CW'(1);
      tick_ff <= 1'b0;
    end
  end

  assign o_tick_port.tick = tick_ff;

endmodule : cer_tick_gen

// File: hdl/cer_bank.sv
// calibration result and enhancement enable register bank with the behaviour its bits steer
// Function
// - monitor offset: two 4-bit fields, upper/lower
// - four single-bit dac/adc offset trims, bits 3..0
// - dac offset: full 8 bits, resets zero
// - common mode: 6 bits, top two read zero
// - peak current: low nibble, upper reads zero
// - boost limit to 41 mA after ring burst
// - tone 1 at 24 kHz when fsk and relay
// - fsk active selects dedicated oscillator registers
// - cadence timers tick at 41.67 us under fsk
// - speedup bit selects multi-threshold converter control
// - external impedance bit removes internal resistor
// - 60 ms debounce high-to-low battery only
// - loop closure from voltage or current
// - squelch bit suppresses converter audio noise
// - hysteresis between upper and lower thresholds
`timescale 1ns/100ps
`include "cer_params.svh"
module cer_bank #(
  parameter int unsigned TONE_SLOW_CYC = `CER_TONE_SLOW_CYC,
  parameter int unsigned TONE_FAST_CYC = `CER_TONE_FAST_CYC,
  parameter int unsigned BATTERY_SWITCH_DEBOUNCE_CYC      = `CER_BATTERY_SWITCH_DEBOUNCE_CYC,
  parameter int unsigned BOOST_CYC     = `CER_BOOST_CYC
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  output logic            o_reg_rvalid,
  input  wire logic       i_cal_we,
  input  wire logic [7:0] i_cal_addr,
  input  wire logic [7:0] i_cal_data,
  input  wire logic       i_relay_flag,
  input  wire logic       i_external_battery_select,
  input  wire logic       i_ring_burst_end,
  input  wire logic [5:0] i_programmed_current_limit,
  input  wire logic       i_batt_high_req,
  input  wire logic [7:0] i_loop_current,
  input  wire logic [7:0] i_tip_ring_voltage,
  input  wire logic [7:0] i_closure_upper,
  input  wire logic [7:0] i_closure_lower,
  output logic      [3:0] o_monitor_offset_result_a,
  output logic      [3:0] o_monitor_offset_result_b,
  output logic            o_dac_positive_trim,
  output logic            o_dac_negative_trim,
  output logic            o_adc_positive_trim,
  output logic            o_adc_negative_trim,
  output logic      [7:0] o_dac_offset_value,
  output logic      [5:0] o_common_mode_value,
  output logic      [3:0] o_peak_current_value,
  output logic      [5:0] o_effective_current_limit,
  output logic            o_programmed_current_limit_boost_active,
  output logic            o_tone1_tick,
  output logic            o_oscillator_one_coeff_use_fsk_regs,
  output logic            o_converter_speedup,
  output logic            o_external_impedance_ref,
  output logic            o_batt_high_sel,
  output logic            o_voltage_loop_closure,
  output logic            o_loop_closed,
  output logic            o_converter_squelch
);

  localparam int unsigned SW = $clog2(BATTERY_SWITCH_DEBOUNCE_CYC + 1);
  localparam int unsigned BW = $clog2(BOOST_CYC + 1);
  localparam logic [SW-1:0] BATTERY_SWITCH_DEBOUNCE_LOAD  = SW'(BATTERY_SWITCH_DEBOUNCE_CYC - 1);
  localparam logic [BW-1:0] BOOST_LOAD = BW'(BOOST_CYC - 1);

  cer_pkg::cer_byte_t     mon_ofs_ff;
  logic [3:0]             trim_ff;
  cer_pkg::cer_byte_t     dac_offset_value_ff;
  logic [5:0]             common_mode_value_ff;
  logic [3:0]             peak_ff;
  cer_pkg::cer_byte_t     enh_ff;

  logic                   host_mon;
  logic                   host_trim;
  logic                   host_dac_offset_value;
  logic                   host_common_mode_value;
  logic                   host_peak;
  logic                   host_enh;
  logic                   cal_mon;
  logic                   cal_trim;
  logic                   cal_dac_offset_value;
  logic                   cal_common_mode_value;
  logic                   cal_peak;

  // calibration engine updates result fields; it wins over a host write in the same cycle
  assign host_mon   = i_reg_wr && (i_reg_addr == `CER_ADDR_MON_OFS);
  assign host_trim  = i_reg_wr && (i_reg_addr == `CER_ADDR_TRIM);
  assign host_dac_offset_value = i_reg_wr && (i_reg_addr == `CER_ADDR_DAC_OFFSET_VALUE);
  assign host_common_mode_value = i_reg_wr && (i_reg_addr == `CER_ADDR_COMMON_MODE_VALUE);
  assign host_peak  = i_reg_wr && (i_reg_addr == `CER_ADDR_PEAK);
  assign host_enh   = i_reg_wr && (i_reg_addr == `CER_ADDR_ENH);
  assign cal_mon    = i_cal_we && (i_cal_addr == `CER_ADDR_MON_OFS);
  assign cal_trim   = i_cal_we && (i_cal_addr == `CER_ADDR_TRIM);
  assign cal_dac_offset_value  = i_cal_we && (i_cal_addr == `CER_ADDR_DAC_OFFSET_VALUE);
  assign cal_common_mode_value  = i_cal_we && (i_cal_addr == `CER_ADDR_COMMON_MODE_VALUE);
  assign cal_peak   = i_cal_we && (i_cal_addr == `CER_ADDR_PEAK);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mon_ofs_ff <= `CER_RST_MON_OFS;
    end else if (cal_mon) begin
      mon_ofs_ff <= i_cal_data;
    end else if (host_mon) begin
      mon_ofs_ff <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      trim_ff <= `CER_RST_TRIM;
    end else if (cal_trim) begin
      trim_ff <= i_cal_data[`CER_TRIM_DAC_POSITIVE_TRIM:0];
    end else if (host_trim) begin
      trim_ff <= i_reg_wdata[`CER_TRIM_DAC_POSITIVE_TRIM:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dac_offset_value_ff <= `CER_RST_DAC_OFFSET_VALUE;
    end else if (cal_dac_offset_value) begin
      dac_offset_value_ff <= i_cal_data;
    end else if (host_dac_offset_value) begin
      dac_offset_value_ff <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      common_mode_value_ff <= `CER_RST_COMMON_MODE_VALUE;
    end else if (cal_common_mode_value) begin
      common_mode_value_ff <= i_cal_data[`CER_COMMON_MODE_VALUE_HI:0];
    end else if (host_common_mode_value) begin
      common_mode_value_ff <= i_reg_wdata[`CER_COMMON_MODE_VALUE_HI:0];
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      peak_ff <= `CER_RST_PEAK;
    end else if (cal_peak) begin
      peak_ff <= i_cal_data[`CER_PEAK_HI:0];
    end else if (host_peak) begin
      peak_ff <= i_reg_wdata[`CER_PEAK_HI:0];
    end
  end

  // enhancement bits are software settings only, calibration never touches them
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enh_ff <= `CER_RST_ENH;
    end else if (host_enh) begin
      enh_ff <= i_reg_wdata;
    end
  end

  // read answer one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rvalid <= 1'b0;
      o_reg_rdata  <= 8'h00;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `CER_ADDR_MON_OFS: o_reg_rdata <= mon_ofs_ff;
          `CER_ADDR_TRIM:    o_reg_rdata <= {4'h0, trim_ff};
          `CER_ADDR_DAC_OFFSET_VALUE:   o_reg_rdata <= dac_offset_value_ff;
          `CER_ADDR_COMMON_MODE_VALUE:   o_reg_rdata <= {2'h0, common_mode_value_ff};
          `CER_ADDR_PEAK:    o_reg_rdata <= {4'h0, peak_ff};
          `CER_ADDR_ENH:     o_reg_rdata <= enh_ff;
          default:           o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign o_monitor_offset_result_a = mon_ofs_ff[`CER_MON_A_HI:`CER_MON_A_LO];
  assign o_monitor_offset_result_b = mon_ofs_ff[`CER_MON_B_HI:`CER_MON_B_LO];
  assign o_dac_positive_trim       = trim_ff[`CER_TRIM_DAC_POSITIVE_TRIM];
  assign o_dac_negative_trim       = trim_ff[`CER_TRIM_DAC_NEGATIVE_TRIM];
  assign o_adc_positive_trim       = trim_ff[`CER_TRIM_ADC_POSITIVE_TRIM];
  assign o_adc_negative_trim       = trim_ff[`CER_TRIM_ADC_NEGATIVE_TRIM];
  assign o_dac_offset_value        = dac_offset_value_ff;
  assign o_common_mode_value       = common_mode_value_ff;
  assign o_peak_current_value      = peak_ff;
  assign o_converter_speedup       = enh_ff[`CER_ENH_CONVERTER_SPEEDUP];
  assign o_external_impedance_ref  = enh_ff[`CER_ENH_EXTERNAL_IMPEDANCE_REF];
  assign o_converter_squelch       = enh_ff[`CER_ENH_CONVERTER_SQUELCH];
  assign o_voltage_loop_closure    = enh_ff[`CER_ENH_VOLTAGE_LOOP_CLOSURE];

  // current limit boost window, restarted by each ring burst end
  logic [BW-1:0] boost_cnt_ff;
  logic          boost_ff;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      boost_ff     <= 1'b0;
      boost_cnt_ff <= '0;
    end else if (!enh_ff[`CER_ENH_PROGRAMMED_CURRENT_LIMIT]) begin
      boost_ff     <= 1'b0;
      boost_cnt_ff <= '0;
    end else if (i_ring_burst_end) begin
      boost_ff     <= 1'b1;
      boost_cnt_ff <= BOOST_LOAD;
    end else if (boost_ff) begin
      if (boost_cnt_ff == '0) begin
        boost_ff <= 1'b0;
      end else begin
        boost_cnt_ff <= boost_cnt_ff - BW'(1);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_effective_current_limit <= 6'h00;
    end else begin
      o_effective_current_limit <= boost_ff ? `CER_PROGRAMMED_CURRENT_LIMIT_BOOST_MA : i_programmed_current_limit;
    end
  end

  assign o_programmed_current_limit_boost_active = boost_ff;

  // tone generator 1 rate; both dividers run so a switch takes effect at the next tick
  cer_tick_if slow_if ();
  cer_tick_if fast_if ();

  cer_tick_gen #(.DIV(TONE_SLOW_CYC)) u_slow_tick (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .o_tick_port (slow_if.src)
  );

  cer_tick_gen #(.DIV(TONE_FAST_CYC)) u_fast_tick (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .o_tick_port (fast_if.src)
  );

  logic fsk_active;
  assign fsk_active = enh_ff[`CER_ENH_FSK] && i_relay_flag;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tone1_tick        <= 1'b0;
      o_oscillator_one_coeff_use_fsk_regs <= 1'b0;
    end else begin
      // same tick drives the cadence timers, so they gain the finer step too
      o_tone1_tick        <= fsk_active ? fast_if.tick : slow_if.tick;
      o_oscillator_one_coeff_use_fsk_regs <= fsk_active;
    end
  end

  // battery switch: only the high-to-low move is debounced
  cer_pkg::cer_batt_state_t batt_state_ff;
  logic [SW-1:0]            batt_cnt_ff;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      batt_state_ff <= cer_pkg::CER_BATT_HIGH;
      batt_cnt_ff   <= '0;
    end else begin
      case (batt_state_ff)
        cer_pkg::CER_BATT_HIGH: begin
          if (!i_batt_high_req) begin
            if (enh_ff[`CER_ENH_BATTERY_SWITCH_DEBOUNCE] && i_external_battery_select) begin
              batt_state_ff <= cer_pkg::CER_BATT_WAIT;
              batt_cnt_ff   <= BATTERY_SWITCH_DEBOUNCE_LOAD;
            end else begin
              batt_state_ff <= cer_pkg::CER_BATT_LOW;
            end
          end
        end
        cer_pkg::CER_BATT_WAIT: begin
          if (i_batt_high_req) begin
            batt_state_ff <= cer_pkg::CER_BATT_HIGH;
          end else if (batt_cnt_ff == '0) begin
            batt_state_ff <= cer_pkg::CER_BATT_LOW;
          end else begin
            batt_cnt_ff <= batt_cnt_ff - SW'(1);
          end
        end
        cer_pkg::CER_BATT_LOW: begin
          if (i_batt_high_req) begin
            batt_state_ff <= cer_pkg::CER_BATT_HIGH;
          end
        end
        default: begin
          batt_state_ff <= cer_pkg::CER_BATT_HIGH;
        end
      endcase
    end
  end

  assign o_batt_high_sel = (batt_state_ff != cer_pkg::CER_BATT_LOW);

  // loop closure; the selected measure is compared unscaled, and larger means closed for either source
  logic [7:0] closure_measure;
  logic       nxt_loop_closed;

  assign closure_measure = enh_ff[`CER_ENH_VOLTAGE_LOOP_CLOSURE] ? i_tip_ring_voltage : i_loop_current;

  always_comb begin
    if (enh_ff[`CER_ENH_HYST] && o_loop_closed) begin
      nxt_loop_closed = (closure_measure >= i_closure_lower);
    end else begin
      nxt_loop_closed = (closure_measure > i_closure_upper);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_loop_closed <= 1'b0;
    end else begin
      o_loop_closed <= nxt_loop_closed;
    end
  end

endmodule : cer_bank

// File: bench/cer_bank_props.sv
// port assertions of the calibration/enhancement register bank
`timescale 1ns/100ps
module cer_bank_props #(
  parameter int unsigned TONE_SLOW_CYC = 12500,
  parameter int unsigned TONE_FAST_CYC = 4166
) (
  input logic       i_sys_clk,
  input logic       i_rst_n,
  input logic [7:0] i_reg_addr,
  input logic       i_reg_wr,
  input logic       i_reg_rd,
  input logic [7:0] i_reg_wdata,
  input logic       i_cal_we,
  input logic [7:0] i_cal_addr,
  input logic       i_relay_flag,
  input logic       i_ring_burst_end,
  input logic [5:0] i_programmed_current_limit,
  input logic       i_batt_high_req,
  input logic [7:0] i_loop_current,
  input logic [7:0] i_tip_ring_voltage,
  input logic [7:0] i_closure_upper,
  input logic [7:0] i_closure_lower,
  input logic       o_reg_rvalid,
  input logic [3:0] o_monitor_offset_result_a,
  input logic [7:0] o_dac_offset_value,
  input logic [5:0] o_common_mode_value,
  input logic [5:0] o_effective_current_limit,
  input logic       o_programmed_current_limit_boost_active,
  input logic       o_tone1_tick,
  input logic       o_oscillator_one_coeff_use_fsk_regs,
  input logic       o_batt_high_sel,
  input logic       o_voltage_loop_closure,
  input logic       o_loop_closed
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0]  meas;
  logic [31:0] gap_ff;
  logic        seen_ff;
  logic        hi_ff;
  logic        lo_ff;
  assign meas = o_voltage_loop_closure ? i_tip_ring_voltage : i_loop_current;
  // host write that no calibration write overrides in the same cycle
  function automatic logic hw(input logic [7:0] a);
    return i_reg_wr && i_reg_addr == a && !(i_cal_we && i_cal_addr == a);
  endfunction : hw
  // a tone interval only counts when the rate flag held one value through all of it
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_ff  <= '0;
      seen_ff <= 1'b0;
      hi_ff   <= 1'b0;
      lo_ff   <= 1'b0;
    end else if (o_tone1_tick) begin
      gap_ff  <= 32'd1;
      seen_ff <= 1'b1;
      hi_ff   <= o_oscillator_one_coeff_use_fsk_regs;
      lo_ff   <= !o_oscillator_one_coeff_use_fsk_regs;
    end else begin
      gap_ff <= gap_ff + 32'd1;
      hi_ff  <= hi_ff & o_oscillator_one_coeff_use_fsk_regs;
      lo_ff  <= lo_ff & !o_oscillator_one_coeff_use_fsk_regs;
    end
  end
  sequence s_boost_rise;
    !o_programmed_current_limit_boost_active ##1 o_programmed_current_limit_boost_active;
  endsequence
  AST_RD_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read not answered");
  AST_MON_A: assert property (hw(8'h67) |=> {4'h0, o_monitor_offset_result_a} == ($past(i_reg_wdata) >> 4))
    else $error("monitor offset upper field wrong");
  AST_DAC_OFFSET_VALUE: assert property (hw(8'h69) |=> o_dac_offset_value == $past(i_reg_wdata))
    else $error("dac offset not written");
  AST_COMMON_MODE_VALUE: assert property (hw(8'h6a) |=> {2'b00, o_common_mode_value} == ($past(i_reg_wdata) & 8'h3f))
    else $error("common mode value wrong");
  AST_DAC_OFFSET_VALUE_HOLD: assert property (!(i_reg_wr && i_reg_addr == 8'h69) && !(i_cal_we && i_cal_addr == 8'h69)
    |=> $stable(o_dac_offset_value)) else $error("dac offset changed without write");
  AST_BOOST: assert property (s_boost_rise |-> $past(i_ring_burst_end) ##1 o_effective_current_limit == 6'd41)
    else $error("boost without burst end or limit not raised");
  AST_LIMIT: assert property (!o_programmed_current_limit_boost_active |=> o_effective_current_limit == $past(i_programmed_current_limit))
    else $error("programmed limit not used");
  AST_FSK_RELAY: assert property (!i_relay_flag |=> !o_oscillator_one_coeff_use_fsk_regs)
    else $error("fsk registers used without relay flag");
  AST_FAST: assert property (o_tone1_tick && seen_ff && hi_ff && o_oscillator_one_coeff_use_fsk_regs |-> gap_ff == TONE_FAST_CYC)
    else $error("fast tone period wrong");
  AST_SLOW: assert property (o_tone1_tick && seen_ff && lo_ff && !o_oscillator_one_coeff_use_fsk_regs |-> gap_ff == TONE_SLOW_CYC)
    else $error("slow tone period wrong");
  AST_BATT_UP: assert property (!o_batt_high_sel && i_batt_high_req |=> o_batt_high_sel)
    else $error("low to high battery delayed");
  AST_BATT_DOWN: assert property ($fell(o_batt_high_sel) |-> !$past(i_batt_high_req))
    else $error("battery dropped while high requested");
  AST_CLOSE: assert property (meas > i_closure_upper |=> o_loop_closed)
    else $error("loop closure missed");
  AST_OPEN: assert property (meas < i_closure_lower |=> !o_loop_closed)
    else $error("loop open missed");
endmodule : cer_bank_props

bind cer_bank cer_bank_props #(
  .TONE_SLOW_CYC(TONE_SLOW_CYC),
  .TONE_FAST_CYC(TONE_FAST_CYC)
) u_props (.*);

// File: bench/tb_top.sv
// self-checking bench of the calibration/enhancement register bank
`timescale 1ns/100ps
module tb_top;
  localparam int SLOW = 10;
  localparam int FAST = 4;
  localparam int DB   = 20;
  localparam int BST  = 8;
  logic       i_sys_clk, i_rst_n, i_reg_wr, i_reg_rd, i_cal_we, i_relay_flag, i_ring_burst_end;
  logic       i_external_battery_select, i_batt_high_req, o_reg_rvalid, o_programmed_current_limit_boost_active;
  logic       o_dac_positive_trim, o_dac_negative_trim, o_adc_positive_trim, o_adc_negative_trim;
  logic       o_tone1_tick, o_oscillator_one_coeff_use_fsk_regs, o_converter_speedup, o_external_impedance_ref;
  logic       o_batt_high_sel, o_voltage_loop_closure, o_loop_closed, o_converter_squelch;
  logic [3:0] o_monitor_offset_result_a, o_monitor_offset_result_b, o_peak_current_value;
  logic [5:0] i_programmed_current_limit, o_common_mode_value, o_effective_current_limit;
  logic [7:0] i_reg_addr, i_reg_wdata, i_cal_addr, i_cal_data, i_loop_current, i_tip_ring_voltage;
  logic [7:0] i_closure_upper, i_closure_lower, o_reg_rdata, o_dac_offset_value, p;
  logic [7:0] pat [3] = '{8'hff, 8'h5a, 8'ha5};
  int         n_mismatch, num_checks, n;

  cer_bank #(.TONE_SLOW_CYC(SLOW), .TONE_FAST_CYC(FAST), .BATTERY_SWITCH_DEBOUNCE_CYC(DB), .BOOST_CYC(BST)) dut_u (.*);

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic step(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // an idle cycle follows each access so a strobe is never lowered and raised in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_addr  = a;
    i_reg_wdata = d;
    i_reg_wr    = 1'b1;
    step(1);
    i_reg_wr = 1'b0;
    step(1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
    i_reg_addr = a;
    i_reg_rd   = 1'b1;
    step(1);
    i_reg_rd = 1'b0;
    chk("rvalid", {7'h0, o_reg_rvalid}, 8'h01);
    chk(nm, o_reg_rdata, exp);
    step(1);
  endtask : rd

  function automatic logic [7:0] msk(input logic [7:0] a);
    case (a)
      8'h68, 8'h6b: return 8'h0f;
      8'h6a:        return 8'h3f;
      8'h6d:        return 8'h00;
      default:      return 8'hff;
    endcase
  endfunction : msk

  task automatic per(output int k);
    int g;
    g = 0;
    while (o_tone1_tick !== 1'b1 && g < 99) begin
      step(1);
      g++;
    end
    k = 0;
    do begin
      step(1);
      k++;
    end while (o_tone1_tick !== 1'b1 && k < 99);
  endtask : per

  task automatic cl(input logic [7:0] ctl, input logic [7:0] cur, input logic [7:0] vlt, input logic exp);
    wr(8'h6c, ctl);
    i_loop_current     = cur;
    i_tip_ring_voltage = vlt;
    step(2);
    chk("closed", {7'h0, o_loop_closed}, {7'h0, exp});
  endtask : cl

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // the sequence needs about 340 cycles
  initial begin
    #300000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {i_reg_wr, i_reg_rd, i_cal_we, i_relay_flag, i_ring_burst_end, i_external_battery_select} = '0;
    {i_reg_addr, i_reg_wdata, i_cal_addr, i_cal_data, i_loop_current, i_tip_ring_voltage} = '0;
    i_batt_high_req            = 1'b1;
    i_closure_upper            = 8'h80;
    i_closure_lower            = 8'h40;
    i_programmed_current_limit = 6'd20;
    i_rst_n                    = 1'b0;
    step(20);
    i_rst_n = 1'b1;
    step(1);
    for (logic [7:0] a = 8'h67; a < 8'h6e; a++) rd(a, (a == 8'h6b) ? 8'h08 : 8'h00, "reset");
    foreach (pat[j]) begin
      p = pat[j];
      for (logic [7:0] a = 8'h67; a < 8'h6e; a++) wr(a, p);
      for (logic [7:0] a = 8'h67; a < 8'h6e; a++) rd(a, p & msk(a), "readback");
      chk("mon", {o_monitor_offset_result_a, o_monitor_offset_result_b}, p);
      chk("trim", {4'h0, o_dac_positive_trim, o_dac_negative_trim, o_adc_positive_trim, o_adc_negative_trim},
          p & 8'h0f);
      chk("dac_offset_value", o_dac_offset_value, p);
      chk("cm", {2'b00, o_common_mode_value}, p & 8'h3f);
      chk("pk", {4'h0, o_peak_current_value}, p & 8'h0f);
      chk("enh", {4'h0, o_converter_speedup, o_external_impedance_ref, o_voltage_loop_closure, o_converter_squelch},
          {4'h0, p[5], p[4], p[2], p[1]});
    end
    i_cal_addr = 8'h69;
    i_cal_data = 8'h77;
    i_cal_we   = 1'b1;
    wr(8'h69, 8'h11);
    i_cal_we   = 1'b0;
    rd(8'h69, 8'h77, "cal wins");
    i_cal_addr = 8'h6a;
    i_cal_data = 8'hff;
    i_cal_we   = 1'b1;
    step(1);
    i_cal_we = 1'b0;
    rd(8'h6a, 8'h3f, "cal cm");
    wr(8'h6c, 8'h80);
    i_ring_burst_end = 1'b1;
    step(1);
    i_ring_burst_end = 1'b0;
    n = 0;
    while (o_programmed_current_limit_boost_active === 1'b1 && n < 99) begin
      if (n == 1) chk("limit 41", {2'b00, o_effective_current_limit}, 8'd41);
      step(1);
      n++;
    end
    chk("boost len", 8'(n), 8'(BST));
    step(1);
    chk("limit", {2'b00, o_effective_current_limit}, 8'd20);
    wr(8'h6c, 8'h00);
    i_ring_burst_end = 1'b1;
    step(1);
    i_ring_burst_end = 1'b0;
    chk("no boost", {7'h0, o_programmed_current_limit_boost_active}, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(8'h6c, {1'b0, m[1], 6'h00});
      i_relay_flag = m[0];
      per(n);
      per(n);
      chk("period", 8'(n), 8'((m == 3) ? FAST : SLOW));
      chk("fsk regs", {7'h0, o_oscillator_one_coeff_use_fsk_regs}, {7'h0, m == 3});
    end
    wr(8'h6c, 8'h08);
    i_external_battery_select = 1'b1;
    i_batt_high_req           = 1'b0;
    step(5);
    i_batt_high_req = 1'b1;
    step(DB);
    chk("abort", {7'h0, o_batt_high_sel}, 8'h01);
    i_batt_high_req = 1'b0;
    n = 0;
    while (o_batt_high_sel === 1'b1 && n < 99) begin
      step(1);
      n++;
    end
    chk("debounce", 8'(n), 8'(DB + 1));
    i_batt_high_req = 1'b1;
    step(1);
    chk("to high", {7'h0, o_batt_high_sel}, 8'h01);
    wr(8'h6c, 8'h00);
    i_batt_high_req = 1'b0;
    step(1);
    chk("no debounce", {7'h0, o_batt_high_sel}, 8'h00);
    i_batt_high_req = 1'b1;
    cl(8'h00, 8'h90, 8'h00, 1'b1);
    cl(8'h00, 8'h60, 8'h00, 1'b0);
    cl(8'h01, 8'h90, 8'h00, 1'b1);
    cl(8'h01, 8'h60, 8'h00, 1'b1);
    cl(8'h01, 8'h30, 8'h00, 1'b0);
    cl(8'h04, 8'h00, 8'h90, 1'b1);
    cl(8'h04, 8'h90, 8'h00, 1'b0);
    i_rst_n = 1'b0;
    step(2);
    i_rst_n = 1'b1;
    step(1);
    rd(8'h69, 8'h00, "rereset");
    wrap_up();
  end
endmodule : tb_top
